// File: verilog/shp_host_port.sv
// Device end of an SRAM-like 16-bit host bus port with direct FIFO mode.
// Assumes host pins are sampled on clk, a receive dword source with a
// one-cycle pop, a register block answering the latch request by the
// next cycle, and a transmit consumer draining the dword FIFO.
`timescale 1ns/1ps
module shp_host_port #(
  parameter int STRAP_W    = shp_pkg::STRAP_W,
  parameter int FIFO_DEPTH = shp_pkg::FIFO_DEPTH
) (
  input  logic                             clk,           // Clock
  input  logic                             rstn,          // Sync reset, also the strap edge
  input  shp_pkg::shp_host_in_type         host_in,       // Host pins
  output logic [shp_pkg::DATA_W-1:0]       host_data_out, // Read data to host
  output logic                             host_data_oe,  // Drive data bus
  input  logic [STRAP_W-1:0]               cfg_strap_in,  // Configuration straps
  output logic [STRAP_W-1:0]               cfg_strap_out, // Straps held from reset
  output shp_pkg::shp_reg_req_type         reg_req,       // Register access
  input  logic [shp_pkg::DATA_W-1:0]       reg_rd_data,   // Register read value
  input  logic                             rx_valid,      // Receive dword present
  input  logic [shp_pkg::DWORD_W-1:0]      rx_data,       // Receive dword
  output logic                             rx_pop,        // Receive dword consumed
  output logic                             tx_valid,      // Transmit dword ready
  output logic [shp_pkg::DWORD_W-1:0]      tx_data,       // Transmit dword
  input  logic                             tx_ready,      // Transmit sink takes it
  output logic                             tx_overrun,    // Transmit dword lost
  output logic                             burst_overrun  // Ordinary burst too long
);
  import shp_pkg::*;

  shp_host_in_type              s1_r;
  shp_host_in_type              s2_r;
  logic                         rd_act_r;
  logic                         wr_act_r;
  logic [ADDR_W:1]              addr_r;
  logic                         sel_r;
  logic [DATA_W-1:0]            wdata_r;
  logic                         rd_now;
  logic                         wr_now;
  logic                         rd_new;
  logic                         rd_leave;
  logic                         wr_end;
  logic                         rd_take;
  logic                         burst_full;
  shp_state_type                state_r;
  logic [1:0]                   wait_r;
  logic                         fetch_sel_r;
  logic                         fetch_hi_r;
  logic [$clog2(BURST_MAX+1)-1:0] burst_cnt_r;
  logic [DATA_W-1:0]            lo_r;
  logic                         pend_r;
  logic [DWORD_W-1:0]           pend_data_r;
  logic                         fifo_in_ready;
  logic                         strap_done_r;

  // ****************************************************************
  // Pin synchroniser and access tracking
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_r <= HOST_IDLE;
      s2_r <= HOST_IDLE;
    end else begin
      s1_r <= host_in;
      s2_r <= s1_r;
    end
  end

  assign rd_now = ~s2_r.chip_sel_low & ~s2_r.read_strobe_low;
  assign wr_now = ~s2_r.chip_sel_low & ~s2_r.write_strobe_low;
  // A changed address inside a held read starts the next burst word
  assign rd_new = rd_now & (~rd_act_r | (s2_r.addr != addr_r)
                  | (s2_r.fifo_sel != sel_r));
  assign rd_leave = rd_act_r & (~rd_now | rd_new);
  assign wr_end = wr_act_r & ~wr_now;
  assign burst_full = (burst_cnt_r == ($bits(burst_cnt_r))'(BURST_MAX));
  assign rd_take = rd_new & (s2_r.fifo_sel | ~rd_act_r | ~burst_full);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
      addr_r   <= '0;
      sel_r    <= 1'b0;
      wdata_r  <= '0;
    end else begin
      rd_act_r <= rd_now;
      wr_act_r <= wr_now;
      if (rd_now || wr_now) begin
        addr_r <= s2_r.addr;
        sel_r  <= s2_r.fifo_sel;
      end
      if (wr_now) begin
        wdata_r <= s2_r.data;
      end
    end
  end

  // ****************************************************************
  // Read sequencing
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r     <= SHP_IDLE;
      wait_r      <= '0;
      fetch_sel_r <= 1'b0;
      fetch_hi_r  <= 1'b0;
    end else if (!rd_now) begin
      state_r <= SHP_IDLE;
    end else if (rd_take) begin
      state_r     <= SHP_FETCH;
      wait_r      <= FETCH_WAIT;
      fetch_sel_r <= s2_r.fifo_sel;
      fetch_hi_r  <= s2_r.addr[LANE_BIT];
    end else begin
      unique case (state_r)
        SHP_FETCH: begin
          if (wait_r == 2'h1) begin
            state_r <= SHP_DRIVE;
          end
          wait_r <= wait_r - 2'h1;
        end
        SHP_IDLE, SHP_DRIVE: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      host_data_out <= '0;
      host_data_oe  <= 1'b0;
    end else begin
      host_data_oe <= rd_now;
      if (state_r == SHP_FETCH && wait_r == 2'h1) begin
        if (!fetch_sel_r) begin
          host_data_out <= reg_rd_data;
        end else if (!rx_valid) begin
          host_data_out <= '0;
        end else if (fetch_hi_r) begin
          host_data_out <= rx_data[DWORD_W-1:DATA_W];
        end else begin
          host_data_out <= rx_data[DATA_W-1:0];
        end
      end
    end
  end

  // Ordinary bursts count their words; direct bursts do not
  always_ff @(posedge clk) begin
    if (!rstn) begin
      burst_cnt_r   <= '0;
      burst_overrun <= 1'b0;
    end else begin
      burst_overrun <= rd_new & ~rd_take;
      if (rd_new && !rd_act_r) begin
        burst_cnt_r <= ($bits(burst_cnt_r))'(1);
      end else if (rd_take && !s2_r.fifo_sel) begin
        burst_cnt_r <= burst_cnt_r + 1'b1;
      end
    end
  end

  // A dword leaves the receive FIFO when its upper half has been read
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_pop <= 1'b0;
    end else begin
      rx_pop <= rd_leave & sel_r & addr_r[LANE_BIT] & rx_valid;
    end
  end

  // ****************************************************************
  // Register access
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_req <= '0;
    end else begin
      reg_req.rd <= rd_take & ~s2_r.fifo_sel;
      reg_req.wr <= wr_end & ~sel_r;
      reg_req.addr  <= rd_new ? s2_r.addr : addr_r;
      reg_req.wdata <= wdata_r;
    end
  end

  // ****************************************************************
  // Transmit path
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lo_r        <= '0;
      pend_r      <= 1'b0;
      pend_data_r <= '0;
      tx_overrun  <= 1'b0;
    end else begin
      tx_overrun <= 1'b0;
      if (pend_r && fifo_in_ready) begin
        pend_r <= 1'b0;
      end
      if (wr_end && sel_r) begin
        if (!addr_r[LANE_BIT]) begin
          lo_r <= wdata_r;
        end else if (pend_r && !fifo_in_ready) begin
          tx_overrun <= 1'b1;
        end else begin
          pend_r      <= 1'b1;
          pend_data_r <= {wdata_r, lo_r};
        end
      end
    end
  end

  shp_fifo #(
    .WIDTH (DWORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (pend_r),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_data_r),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strap_done_r  <= 1'b0;
      cfg_strap_out <= '0;
    end else if (!strap_done_r) begin
      strap_done_r  <= 1'b1;
      cfg_strap_out <= cfg_strap_in;
    end
  end

endmodule : shp_host_port

// File: verilog/shp_pkg.sv
// Shared types and constants of the host bus port.
// Assumes one 100 MHz clock and a host that keeps its own strobe timing.
package shp_pkg;

  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int ADDR_W     = 7;   // Address pins 7 down to 1
  localparam int DATA_W     = 16;
  localparam int DWORD_W    = 32;
  localparam int STRAP_W    = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int BURST_MAX  = 16;  // Words per ordinary burst
  localparam int LANE_BIT   = 1;   // Address bit choosing the dword half

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int T_CSH_NS        = 13;
  localparam int T_CSH_CYC       = (T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_DSU_NS        = 7;
  localparam int T_ACYC_NS       = 45;
  localparam int T_ADV_NS        = 40;
  localparam int T_ADV_CYC       = (T_ADV_NS / CLK_PERIOD_NS < 1) ? 1 : T_ADV_NS / CLK_PERIOD_NS;
  localparam int T_STRAP_SU_NS   = 200;
  localparam int FETCH_WAIT_CYC  = 2;  // Lets a preceding pop reach the data
  localparam logic [1:0] FETCH_WAIT = 2'h2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic              chip_sel_low;
    logic              read_strobe_low;
    logic              write_strobe_low;
    logic              fifo_sel;
    logic [ADDR_W:1]   addr;
    logic [DATA_W-1:0] data;
  } shp_host_in_type;

  localparam shp_host_in_type HOST_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 7'h00, 16'h0000};

  typedef struct packed {
    logic              rd;     // One-cycle latch request for a register read
    logic              wr;     // One-cycle register write
    logic [ADDR_W:1]   addr;
    logic [DATA_W-1:0] wdata;
  } shp_reg_req_type;

  typedef enum logic [1:0] {
    SHP_IDLE,
    SHP_FETCH,
    SHP_DRIVE
  } shp_state_type;

endpackage : shp_pkg

// File: verilog/shp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module shp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  logic             clk,       // Clock
  input  logic             rstn,      // Synchronous reset, active low
  input  logic             in_valid,  // Word offered
  output logic             in_ready,  // Room for a word
  input  logic [WIDTH-1:0] in_data,   // Word in
  output logic             out_valid, // Word available
  input  logic             out_ready, // Sink takes word
  output logic [WIDTH-1:0] out_data   // Oldest word
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW-1:0]    rp_nxt;
  logic [AW:0]      cnt_r;
  logic             valid_r;
  logic [WIDTH-1:0] head_r;
  logic             push;
  logic             pop;
  logic             load_in;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = valid_r;
  assign out_data  = head_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign rp_nxt    = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
  // Incoming word becomes the head when the FIFO is, or is about to be, empty
  assign load_in   = push & ((cnt_r == '0) | (pop & (cnt_r == (AW+1)'(1))));

  // ****************************************************************
  // Storage
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // ****************************************************************
  // Pointers and fill level
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_nxt;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // ****************************************************************
  // Registered head word and valid flag
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      valid_r <= 1'b0;
      head_r  <= '0;
    end else begin
      if (load_in) begin
        head_r <= in_data;
      end else if (pop) begin
        head_r <= mem[rp_nxt];
      end
      if (push && !pop) begin
        valid_r <= 1'b1;
      end else if (pop && !push && cnt_r == (AW+1)'(1)) begin
        valid_r <= 1'b0;
      end
    end
  end

endmodule : shp_fifo

// File: bench/shp_host_port_props.sv
// Checker of the host port outputs against its pins.
// Bound to every shp_host_port; sees only its ports.
`timescale 1ns/1ps
module shp_host_port_props #(
  parameter int STRAP_W = 4
) (
  input logic                     clk,           // Clock
  input logic                     rstn,          // Reset
  input shp_pkg::shp_host_in_type host_in,       // Pins
  input logic                     host_data_oe,  // Drive
  input logic [STRAP_W-1:0]       cfg_strap_in,  // Straps
  input logic [STRAP_W-1:0]       cfg_strap_out, // Held
  input shp_pkg::shp_reg_req_type reg_req,       // Register
  input logic                     rx_valid,      // Source
  input logic                     rx_pop,        // Pop
  input logic                     tx_valid,      // Sink
  input logic                     tx_overrun,    // Lost
  input logic                     burst_overrun  // Long
);
  import shp_pkg::*;
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_oe_on;
    (!host_in.chip_sel_low && !host_in.read_strobe_low)[*5] |-> host_data_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("read not driven");
  property p_oe_off;
    (host_in.chip_sel_low || host_in.read_strobe_low)[*5] |-> !host_data_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive after read");
  property p_pop_once; rx_pop |=> !rx_pop; endproperty
  a_pop_once: assert property (p_pop_once) else $error("double pop");
  // Pin to pop is four edges: two sync flops, the select hold and the pop flop
  property p_pop_src; rx_pop |-> $past(rx_valid) && $past(host_in.fifo_sel, 4); endproperty
  a_pop_src: assert property (p_pop_src) else $error("bad pop");
  property p_rd_reg; reg_req.rd |-> !$past(host_in.fifo_sel, 3) ##1 !reg_req.rd; endproperty
  a_rd_reg: assert property (p_rd_reg) else $error("bad latch");
  property p_wr_reg; reg_req.wr |-> !$past(host_in.fifo_sel, 4) ##1 !reg_req.wr; endproperty
  a_wr_reg: assert property (p_wr_reg) else $error("bad write");
  property p_bo; burst_overrun |-> !$past(host_in.fifo_sel, 3); endproperty
  a_bo: assert property (p_bo) else $error("direct burst cut");
  property p_txo; tx_overrun |-> tx_valid; endproperty
  a_txo: assert property (p_txo) else $error("loss with room");
  property p_strap;
    rstn && $past(rstn) && !$past(rstn, 2) |-> cfg_strap_out == $past(cfg_strap_in);
  endproperty
  a_strap: assert property (p_strap) else $error("strap miss");
  property p_hold; $past(rstn) && $past(rstn, 2) |-> $stable(cfg_strap_out); endproperty
  a_hold: assert property (p_hold) else $error("strap moved");
  c_pop: cover property (rx_pop);
  c_wr: cover property (reg_req.wr);
  c_txo: cover property (tx_overrun);
  c_bo: cover property (burst_overrun);
endmodule : shp_host_port_props

bind shp_host_port shp_host_port_props #(.STRAP_W(STRAP_W)) u_props (.clk, .rstn, .host_in,
  .host_data_oe, .cfg_strap_in, .cfg_strap_out, .reg_req, .rx_valid, .rx_pop, .tx_valid,
  .tx_overrun, .burst_overrun);

// File: bench/shp_host_model.sv
// Host bus master model: SRAM-like cycles on the port pins.
// Assumes its tasks are called from one testbench process.
`timescale 1ns/1ps
module shp_host_model (
  input  logic                     clk,    // Clock
  output shp_pkg::shp_host_in_type host_in // Pins
);
  import shp_pkg::*;
  // ****
  // Cycles
  // ****
  initial host_in = HOST_IDLE;
  task automatic start(input logic w, input logic f, input logic [ADDR_W:1] a,
                       input logic [DATA_W-1:0] d);
    @(posedge clk);
    host_in.chip_sel_low     <= 1'b0;
    host_in.read_strobe_low  <= w;
    host_in.write_strobe_low <= !w;
    host_in.fifo_sel         <= f;
    host_in.addr             <= a;
    host_in.data             <= w ? d : ~host_in.data;
    repeat (7) @(posedge clk);
  endtask : start
  task automatic step(input logic [ADDR_W:1] a);
    @(posedge clk);
    host_in.addr <= a;
    repeat (7) @(posedge clk);
  endtask : step
  task automatic wdat(input logic [DATA_W-1:0] d);
    @(posedge clk);
    host_in.data <= d;
    repeat (2) @(posedge clk);
  endtask : wdat
  // Ends by chip select or by both strobes; address stays, released data inverts
  task automatic stop(input logic by_cs);
    @(posedge clk);
    if (by_cs)
      host_in.chip_sel_low <= 1'b1;
    else begin
      host_in.read_strobe_low  <= 1'b1;
      host_in.write_strobe_low <= 1'b1;
    end
    host_in.data <= ~host_in.data;
    repeat (6) @(posedge clk);
  endtask : stop
endmodule : shp_host_model

// File: bench/shp_host_port_tb_top.sv
// Testbench: host model, receive source, register stub and
// transmit sink around one port, compared with queue models.
`timescale 1ns/1ps
module shp_host_port_tb_top;
  import shp_pkg::*;
  logic                 clk, rstn = 1'b0, tx_ready = 1'b0, stall = 1'b1;
  logic                 rx_valid = 1'b0, rx_pop, tx_valid, tx_overrun, burst_overrun;
  logic                 host_data_oe;
  logic [STRAP_W-1:0]   cfg_strap_in = '0, cfg_strap_out;
  logic [DATA_W-1:0]    host_data_out, reg_rd_data = '0;
  logic [DWORD_W-1:0]   rx_data = '0, tx_data, w, srcq[$], txq[$], exq[$];
  logic [ADDR_W:1]      a;
  logic [22:0]          wexp;
  shp_host_in_type      host_in;
  shp_reg_req_type      reg_req;
  int                   n_mismatch = 0, checks_done = 0, n_bo = 0, n_txo = 0;
  int                   n_wr = 0, n_pop = 0;
  integer               seed = 32'hd484_1697;

  shp_host_model host (.clk, .host_in);
  shp_host_port uut (.clk, .rstn, .host_in, .host_data_out, .host_data_oe, .cfg_strap_in,
    .cfg_strap_out, .reg_req, .reg_rd_data, .rx_valid, .rx_data, .rx_pop, .tx_valid,
    .tx_data, .tx_ready, .tx_overrun, .burst_overrun);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****
  // Tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  function automatic logic [15:0] regval(input logic [ADDR_W:1] x);
    return {x, 2'h2, x};
  endfunction : regval
  task automatic rd_chk(input logic [15:0] exp);
    check(host_data_out, exp);
    check(host_data_oe, 1'b1);
  endtask : rd_chk
  task automatic do_reset(input logic [STRAP_W-1:0] s);
    @(posedge clk);
    rstn <= 1'b0;
    cfg_strap_in <= s;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    cfg_strap_in <= ~s;
    repeat (2) @(posedge clk);
    check(cfg_strap_out, s);
  endtask : do_reset
  // ****
  // Far side stubs and monitors
  // ****
  always @(posedge clk) begin
    reg_rd_data <= reg_req.rd ? regval(reg_req.addr) : reg_rd_data + 16'h0001;
    if (rx_pop) begin
      void'(srcq.pop_front());
      n_pop++;
    end
    rx_valid <= srcq.size() > 0;
    rx_data <= (srcq.size() > 0) ? srcq[0] : ~rx_data;
    tx_ready <= !stall & 1'($random(seed));
    if (reg_req.wr) begin
      n_wr++;
      check({reg_req.addr, reg_req.wdata}, wexp);
    end
    if (tx_valid && tx_ready)
      check(tx_data, txq.pop_front());
    n_bo += burst_overrun;
    n_txo += tx_overrun;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    do_reset(4'($random(seed)));
    for (int i = 0; i < 4; i++) begin
      a = 7'($random(seed));
      w = $random(seed);
      wexp = {a, w[31:16]};
      host.start(1'b1, 1'b0, a, w[15:0]);
      host.wdat(w[31:16]);
      host.stop(1'(i));
    end
    check(n_wr, 4);
    a = 7'h10;
    host.start(1'b0, 1'b0, a, 16'h0000);
    for (int i = 0; i < 17; i++) begin
      if (i > 0)
        host.step(a + 7'(i));
      rd_chk(regval(a + 7'(i < 16 ? i : 15)));
    end
    host.stop(1'b0);
    check(n_bo, 1);
    $display("register test done");
    for (int i = 0; i < 10; i++) begin
      w = $random(seed);
      if (i < 9)
        txq.push_back(w);
      for (int h = 0; h < 2; h++) begin
        host.start(1'b1, 1'b1, {5'($random(seed)), 1'b0, 1'(h)}, h ? w[31:16] : w[15:0]);
        host.stop(1'(h));
      end
    end
    check(n_txo, 1);
    check(n_wr, 4);
    stall = 1'b0;
    repeat (80) @(posedge clk);
    check(txq.size(), 0);
    check(tx_valid, 1'b0);
    $display("transmit test done");
    repeat (20) srcq.push_back($random(seed));
    exq = srcq;
    for (int i = 0; i < 40; i++) begin
      a = {5'($random(seed)), 1'b0, 1'(i)};
      if (i == 0)
        host.start(1'b0, 1'b1, a, 16'h0000);
      else
        host.step(a);
      rd_chk(i[0] ? exq[i/2][31:16] : exq[i/2][15:0]);
    end
    host.stop(1'b1);
    check(n_bo, 1);
    check(n_pop, 20);
    host.start(1'b0, 1'b1, 7'h7b, 16'h0000);
    rd_chk(16'h0000);
    host.stop(1'b0);
    check(n_pop, 20);
    $display("receive test done");
    do_reset(4'($random(seed)));
    $display("reset test done");
    print_verdict();
  end
endmodule : shp_host_port_tb_top
